// [margin_dac_code_limiter.sv]
// The APB register port was left to the implementer.
`timescale 1ns/10ps
module margin_dac_code_limiter
  import margin_dac_pkg::*;
(
  input wire logic pclk, // apb clock, 25 MHz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [ADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  output dac_drive_s ch5_drive, // applied drive, channel 5
  output dac_drive_s ch6_drive // applied drive, channel 6
);
  logic [7:0] ctrl_ff [2];
  logic [7:0] code_ff [2];
  logic [7:0] upper_ff [2];
  logic [7:0] lower_ff [2];
  dac_drive_s drive_ff [2];
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;

  logic [7:0] idx;
  logic setup;
  logic hit;
  logic [31:0] nxt_rdata;
  logic [7:0] wbyte;
  logic access_wr;
  logic [1:0] wr_ctrl;
  logic [1:0] wr_code;
  logic [1:0] wr_upper;
  logic [1:0] wr_lower;
  logic [1:0] inverted;
  logic [1:0] nxt_enable;
  midcode_sel_e nxt_select [2];
  logic [7:0] nxt_code [2];

  assign idx = paddr[IDX_LSB +: 8];
  assign setup = psel && !penable;
  assign wbyte = pwdata[7:0];

  always_comb begin
    hit = 1'b1;
    nxt_rdata = '0;
    unique case (idx)
      CH5_CTRL_IDX: nxt_rdata[7:0] = ctrl_ff[0] & CTRL_MASK;
      CH6_CTRL_IDX: nxt_rdata[7:0] = ctrl_ff[1] & CTRL_MASK;
      CH5_CODE_IDX: nxt_rdata[7:0] = code_ff[0];
      CH6_CODE_IDX: nxt_rdata[7:0] = code_ff[1];
      CH5_UPPER_IDX: nxt_rdata[7:0] = upper_ff[0];
      CH6_UPPER_IDX: nxt_rdata[7:0] = upper_ff[1];
      CH5_LOWER_IDX: nxt_rdata[7:0] = lower_ff[0];
      CH6_LOWER_IDX: nxt_rdata[7:0] = lower_ff[1];
      CH5_STATUS_IDX: nxt_rdata[7:0] = drive_ff[0].code;
      CH6_STATUS_IDX: nxt_rdata[7:0] = drive_ff[1].code;
      default: hit = 1'b0;
    endcase
  end

  // no wait state: answer is registered during setup, ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= setup;
    end
  end

  // error rides with ready, so it stands exactly as long as the answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_ff <= 1'b0;
    end else begin
      pslverr_ff <= setup && !hit;
    end
  end

  // read data is zero outside a read answer, keeping the bus quiet between transfers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= '0;
    end else begin
      prdata_ff <= (setup && !pwrite) ? nxt_rdata : '0;
    end
  end

  // writes land at the completing edge; status and unmapped writes are ignored
  assign access_wr = psel && penable && pready_ff && pwrite;

  always_comb begin
    wr_ctrl = '0;
    wr_code = '0;
    wr_upper = '0;
    wr_lower = '0;
    if (access_wr) begin
      unique case (idx)
        CH5_CTRL_IDX: wr_ctrl[0] = 1'b1;
        CH6_CTRL_IDX: wr_ctrl[1] = 1'b1;
        CH5_CODE_IDX: wr_code[0] = 1'b1;
        CH6_CODE_IDX: wr_code[1] = 1'b1;
        CH5_UPPER_IDX: wr_upper[0] = 1'b1;
        CH6_UPPER_IDX: wr_upper[1] = 1'b1;
        CH5_LOWER_IDX: wr_lower[0] = 1'b1;
        CH6_LOWER_IDX: wr_lower[1] = 1'b1;
        default: ;
      endcase
    end
  end

  // unused control bits are dropped on the way in, so they always read zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < 2; c++) begin
        ctrl_ff[c] <= '0;
      end
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (wr_ctrl[c]) begin
          ctrl_ff[c] <= wbyte & CTRL_MASK;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < 2; c++) begin
        code_ff[c] <= MIDCODE;
      end
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (wr_code[c]) begin
          code_ff[c] <= wbyte;
        end
      end
    end
  end

  // limits reset wide open so the midcode passes untouched until software narrows them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < 2; c++) begin
        upper_ff[c] <= UPPER_RST;
      end
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (wr_upper[c]) begin
          upper_ff[c] <= wbyte;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < 2; c++) begin
        lower_ff[c] <= LOWER_RST;
      end
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (wr_lower[c]) begin
          lower_ff[c] <= wbyte;
        end
      end
    end
  end

  // upper is tested first, so an inverted pair still yields a defined code
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      inverted[c] = lower_ff[c] > upper_ff[c];
      nxt_select[c] = midcode_sel_e'(ctrl_ff[c][1:0]);
      nxt_enable[c] = ctrl_ff[c][ENABLE_BIT] && !inverted[c];
      if (code_ff[c] > upper_ff[c]) begin
        nxt_code[c] = upper_ff[c];
      end else if (code_ff[c] < lower_ff[c]) begin
        nxt_code[c] = lower_ff[c];
      end else begin
        nxt_code[c] = code_ff[c];
      end
    end
  end

  // inverted limits leave no legal code, so the channel is shut off instead
  // drive is registered: it follows a register write by one clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < 2; c++) begin
        drive_ff[c] <= '{enable: 1'b0, midcode_voltage_select: MID_1V25, code: MIDCODE};
      end
    end else begin
      for (int c = 0; c < 2; c++) begin
        drive_ff[c].midcode_voltage_select <= nxt_select[c];
        drive_ff[c].enable <= nxt_enable[c];
        drive_ff[c].code <= nxt_code[c];
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign ch5_drive = drive_ff[0];
  assign ch6_drive = drive_ff[1];
endmodule

// [margin_dac_pkg.sv]
// Behaviour
// - eight-bit code register, 0x7F is midcode
// - code above upper clamp applies upper clamp
// - code below lower clamp applies lower clamp
// - lower clamp above upper forces output off
// - control bits one-zero pick midcode voltage
package margin_dac_pkg;
  // printed offsets are not all multiples of four: they are indexes, byte address is four times
  localparam logic [7:0] CH5_CTRL_IDX = 8'h54;
  localparam logic [7:0] CH6_CTRL_IDX = 8'h55;
  localparam logic [7:0] CH5_CODE_IDX = 8'h5C;
  localparam logic [7:0] CH6_CODE_IDX = 8'h5D;
  localparam logic [7:0] CH5_UPPER_IDX = 8'h64;
  localparam logic [7:0] CH6_UPPER_IDX = 8'h65;
  localparam logic [7:0] CH5_LOWER_IDX = 8'h6C;
  localparam logic [7:0] CH6_LOWER_IDX = 8'h6D;
  localparam logic [7:0] CH5_STATUS_IDX = 8'h70;
  localparam logic [7:0] CH6_STATUS_IDX = 8'h71;
  localparam int ADDR_W = 10;
  localparam int IDX_LSB = 2;
  localparam logic [7:0] MIDCODE = 8'h7F;
  localparam logic [7:0] UPPER_RST = 8'hFF;
  localparam logic [7:0] LOWER_RST = 8'h00;
  localparam int ENABLE_BIT = 2;
  localparam logic [7:0] CTRL_MASK = 8'h07;

  typedef enum logic [1:0] {
    MID_1V25,
    MID_1V00,
    MID_0V80,
    MID_0V60
  } midcode_sel_e;

  typedef struct packed {
    logic enable;
    midcode_sel_e midcode_voltage_select;
    logic [7:0] code;
  } dac_drive_s;
endpackage

// [margin_dac_monitor.sv]
`timescale 1ns/10ps
module margin_dac_monitor
  import margin_dac_pkg::*;
(
  input wire logic pclk, presetn, psel, penable, pwrite, pready,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire dac_drive_s ch6_drive
);
  logic [7:0] cd_ff, up_ff, lo_ff;
  logic [2:0] ct_ff;
  wire acc = psel && penable && pready;
  wire [2:0] hi = {ct_ff[2] && lo_ff <= up_ff, ct_ff[1:0]};
  // shadow of channel 6 registers, updated on the same edge as the design's
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) {ct_ff, cd_ff, up_ff, lo_ff} <= {3'h0, MIDCODE, UPPER_RST, LOWER_RST};
    else if (acc && pwrite)
      case (paddr[9:2])
        CH6_CTRL_IDX: ct_ff <= pwdata[2:0];
        CH6_CODE_IDX: cd_ff <= pwdata[7:0];
        CH6_UPPER_IDX: up_ff <= pwdata[7:0];
        CH6_LOWER_IDX: lo_ff <= pwdata[7:0];
        default: ;
      endcase
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_mid; $rose(presetn) |-> ch6_drive == {3'h0, MIDCODE}; endproperty
  a_mid: assert property (p_mid) else $error("drive not midcode");
  property p_up; cd_ff > up_ff |=> ch6_drive.code == $past(up_ff); endproperty
  a_up: assert property (p_up) else $error("upper clamp missed");
  property p_lo; cd_ff < lo_ff && cd_ff <= up_ff |=> ch6_drive.code == $past(lo_ff); endproperty
  a_lo: assert property (p_lo) else $error("lower clamp missed");
  property p_inv; lo_ff > up_ff |=> !ch6_drive.enable; endproperty
  a_inv: assert property (p_inv) else $error("inverted clamps enabled");
  property p_sel; 1'h1 |=> {ch6_drive.enable, ch6_drive.midcode_voltage_select} == $past(hi); endproperty
  a_sel: assert property (p_sel) else $error("select or enable wrong");
  property p_rd; acc && !pwrite && paddr[9:2] == CH6_CTRL_IDX |-> prdata == {29'h0, ct_ff}; endproperty
  a_rd: assert property (p_rd) else $error("control readback wrong");
endmodule
bind margin_dac_code_limiter margin_dac_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pready(pready), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .ch6_drive(ch6_drive));

// [margin_dac_code_limiter_bench.sv]
`timescale 1ns/10ps
module margin_dac_code_limiter_bench;
  import margin_dac_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [7:0] k, c, u, l;
  dac_drive_s d5, d6;
  int err_total = 0, checks = 0, cyc = 0;
  always #20 pclk = ~pclk;
  always @(posedge pclk) if (++cyc > 9000) begin err_total++; wrap_up; end
  margin_dac_code_limiter DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ch5_drive(d5),
    .ch6_drive(d6));
  task automatic chk(input logic [31:0] g, e);
    checks++;
    if (g !== e) begin err_total++; $display("ERROR %0t got %h exp %h", $time, g, e); end
  endtask
  task automatic xf(input logic w, input logic [7:0] i, d);
    {psel, pwrite, paddr, pwdata} <= {1'h1, w, i, 2'h0, 24'h0, d};
    @(posedge pclk) penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    {rd, er} = {prdata, pslverr};
    {psel, penable} <= 2'h0;
    @(posedge pclk);
  endtask
  function automatic logic [7:0] clamp_of(input logic [7:0] cd, hi, lo);
    return cd > hi ? hi : cd < lo ? lo : cd;
  endfunction
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h1FD0A5DD));
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    chk(d5, 32'h7F);
    for (int t = 0; t < 40; t++) begin
      {k, c, u, l} = $urandom;
      if (t < 8) k = 8'hF8 | t[7:0]; // each select and enable, with junk in unused bits
      if (t == 9) {c, u, l} = 24'h10FF80;
      xf(1'h1, CH5_CTRL_IDX + t[0], k);
      xf(1'h1, CH5_CODE_IDX + t[0], c);
      xf(1'h1, CH5_UPPER_IDX + t[0], u);
      xf(1'h1, CH5_LOWER_IDX + t[0], l);
      xf(1'h0, CH5_CTRL_IDX + t[0], 8'h00);
      chk(rd, k & CTRL_MASK);
      chk(t[0] ? d6 : d5, {k[2] && l <= u, k[1:0], clamp_of(c, u, l)});
      xf(1'h0, CH5_STATUS_IDX + t[0], 8'h00);
      chk(rd, clamp_of(c, u, l));
      $display("test %0d done", t);
    end
    xf(1'h1, 8'h00, 8'hFF);
    chk(er, 1'h1);
    presetn <= 1'h0;
    @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    chk(d6, 32'h7F);
    xf(1'h0, CH6_CODE_IDX, 8'h00);
    chk(rd, 32'h7F);
    wrap_up;
  end
endmodule
